// [hdl/swc_consts.svh]
// Constants for the sleep and wake-up controller: offsets, fields, resets, timing
// Behaviour
// - Power-down entered only by the sleep instruction
// - Sleep: clear watchdog, timeout set, powerdown cleared, oscillator off
// - Port pins hold their drive state while asleep
// - Watchdog reset stays internal, never drives reset pin
// - Wake on reset pin, watchdog, pin or comparator change
// - Every wake produces a full device reset
// - Watchdog timeout clears the timeout flag
// - Powerdown flag set at power-up, cleared by sleep
// - Pin-change flag on pins 0,1,3 mismatch
// - Comparator flag on comparator change while asleep
// - Pin compare uses last port read values
// - Watchdog cleared on every wake
// - Flags hold until reset; reset pin keeps them unless a same-cycle sleep or clear watchdog moves powerdown
// - Wake flags read exclusive with timeout 1, powerdown 0
// - Watchdog keeps counting while main oscillator stopped
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SWC_OFS_FLAGS     5'h00
`define SWC_OFS_CTRL      5'h04
`define SWC_OFS_IRQ_STAT  5'h08
`define SWC_OFS_IRQ_MASK  5'h0c
`define SWC_OFS_STATE     5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWC_FLG_POWERDOWN 3
`define SWC_FLG_TIMEOUT   4
`define SWC_FLG_CMP_WAKE  6
`define SWC_FLG_PIN_WAKE  7
`define SWC_CTL_WDT_EN    0
`define SWC_CTL_PIN_EN    1
`define SWC_CTL_CMP_EN    2
`define SWC_CTL_RSTPIN_EN 3
`define SWC_IRQ_WAKE      0
`define SWC_IRQ_WDT       1
`define SWC_IRQ_SLEEP     2
`define SWC_ST_OSC_BIT    2

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define SWC_CTRL_RST      4'h9
`define SWC_IRQ_MASK_RST  3'h0
`define SWC_PIN_WAKE_MASK 4'hb

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWC_CLK_NS        10
`define SWC_WDT_PERIOD_US 18000
`define SWC_US_NS         1000
`define SWC_TICK_CYC      (`SWC_US_NS / `SWC_CLK_NS)
`define SWC_DRT_NS        10000
`define SWC_DRT_CYC       (`SWC_DRT_NS / `SWC_CLK_NS)

`endif

// [hdl/swc_pkg.sv]
// Types shared by the sleep and wake-up controller
package swc_pkg;

    // Gray coded along run, sleep, reset
    typedef enum logic [1:0] {
        SWC_RUN   = 2'b00,
        SWC_SLEEP = 2'b01,
        SWC_RESET = 2'b11
    } swc_state_e;

    typedef logic [20:0] swc_wdt_cnt_t;

endpackage

// [hdl/swc_watchdog.sv]
// Watchdog counter on its own microsecond tick
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_watchdog
    import swc_pkg::*;
#(
    parameter int WDT_PERIOD_US = `SWC_WDT_PERIOD_US
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Control
    input  wire logic i_enable,
    input  wire logic i_clear,
    // Event
    output logic      o_timeout
);
    localparam logic [6:0]   TICK_LAST = 7'(`SWC_TICK_CYC - 1);
    localparam swc_wdt_cnt_t WDT_LAST  = 21'(WDT_PERIOD_US - 1);

    logic [6:0]   tick_reg;
    logic [6:0]   tick_next;
    swc_wdt_cnt_t cnt_reg;
    swc_wdt_cnt_t cnt_next;
    logic         to_reg;
    logic         to_next;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Tick divider free runs so the count never depends on the main oscillator gate
    always_comb begin
        tick_next = (tick_reg == TICK_LAST) ? 7'h00 : tick_reg + 7'h01;
        cnt_next  = cnt_reg;
        to_next   = 1'b0;
        if (i_clear || !i_enable) begin
            cnt_next = '0;
        end else if (tick_reg == TICK_LAST) begin
            if (cnt_reg == WDT_LAST) begin
                cnt_next = '0;
                to_next  = 1'b1;
            end else begin
                cnt_next = cnt_reg + 21'h000001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tick_reg <= 7'h00;
            cnt_reg  <= '0;
            to_reg   <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            cnt_reg  <= cnt_next;
            to_reg   <= to_next;
        end
    end

    assign o_timeout = to_reg;
endmodule

// [hdl/swc_sleep_wakeup_control.sv]
// Sleep entry, wake detection, reset-cause flags and register slave
`timescale 1ns/1ps
`include "swc_consts.svh"
module swc_sleep_wakeup_control
    import swc_pkg::*;
#(
    parameter int WDT_PERIOD_US = `SWC_WDT_PERIOD_US
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    // Core side
    input  wire logic        i_sleep_exec,
    input  wire logic        i_clrwdt_exec,
    input  wire logic        i_port_access,
    input  wire logic [3:0]  i_core_port_out,
    input  wire logic [3:0]  i_core_port_oe_n,
    output logic             o_core_rst,
    output logic             o_osc_en,
    output logic             o_timeout_flag,
    output logic             o_powerdown_flag,
    output logic             o_pin_change_wake_flag,
    output logic             o_comparator_wake_flag,
    // Pins and analog
    input  wire logic        i_external_reset_pin_n,
    input  wire logic [3:0]  i_port_pin,
    input  wire logic        i_cmp_out,
    output logic [3:0]       o_port_pin,
    output logic [3:0]       o_port_pin_oe_n
);
    localparam logic [9:0] DRT_LAST = 10'(`SWC_DRT_CYC - 1);

    swc_state_e  state_reg;
    swc_state_e  state_next;
    logic [9:0]  drt_reg;
    logic [9:0]  drt_next;
    logic        core_rst_reg;
    logic        core_rst_next;
    logic        osc_reg;
    logic        osc_next;
    logic [3:0]  pout_reg;
    logic [3:0]  pout_next;
    logic [3:0]  poe_reg;
    logic [3:0]  poe_next;
    logic [3:0]  snap_reg;
    logic [3:0]  snap_next;
    logic        csnap_reg;
    logic        csnap_next;
    logic        to_reg;
    logic        to_next;
    logic        pd_reg;
    logic        pd_next;
    logic        pinw_reg;
    logic        pinw_next;
    logic        cmpw_reg;
    logic        cmpw_next;
    logic [3:0]  ctrl_reg;
    logic [3:0]  ctrl_next;
    logic [2:0]  ist_reg;
    logic [2:0]  ist_next;
    logic [2:0]  imsk_reg;
    logic [2:0]  imsk_next;
    logic        irq_reg;
    logic        irq_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;

    logic wdt_to;
    logic wdt_clr;
    logic sleep_go;
    logic ext_rst;
    logic pin_wake;
    logic cmp_wake;
    logic any_wake;
    logic wr_ok;
    logic rd_ist;

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Cleared on sleep entry and as any wake is taken
    assign wdt_clr = sleep_go || any_wake || (i_clrwdt_exec && state_reg == SWC_RUN);

    swc_watchdog #(
        .WDT_PERIOD_US (WDT_PERIOD_US)
    ) u_watchdog (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_enable  (ctrl_reg[`SWC_CTL_WDT_EN]),
        .i_clear   (wdt_clr),
        .o_timeout (wdt_to)
    );

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // Sleep is only ever reached from the instruction strobe
    assign sleep_go = (state_reg == SWC_RUN) && i_sleep_exec;
    assign ext_rst  = ctrl_reg[`SWC_CTL_RSTPIN_EN] && !i_external_reset_pin_n;
    // Compare against last port read, so stale mismatch wakes at once
    assign pin_wake = (state_reg == SWC_SLEEP) && ctrl_reg[`SWC_CTL_PIN_EN]
                      && |((i_port_pin ^ snap_reg) & `SWC_PIN_WAKE_MASK);
    assign cmp_wake = (state_reg == SWC_SLEEP) && ctrl_reg[`SWC_CTL_CMP_EN]
                      && (i_cmp_out != csnap_reg);
    assign any_wake = (state_reg == SWC_SLEEP) && (ext_rst || wdt_to || pin_wake || cmp_wake);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A wake never resumes; it always runs the reset timer first
    always_comb begin
        state_next = state_reg;
        drt_next   = drt_reg;
        case (state_reg)
            SWC_RUN: begin
                if (ext_rst || wdt_to) begin
                    state_next = SWC_RESET;
                    drt_next   = 10'h000;
                end else if (sleep_go) begin
                    state_next = SWC_SLEEP;
                end
            end
            SWC_SLEEP: begin
                if (any_wake) begin
                    state_next = SWC_RESET;
                    drt_next   = 10'h000;
                end
            end
            SWC_RESET: begin
                if (ext_rst) begin
                    drt_next = 10'h000;
                end else if (drt_reg == DRT_LAST) begin
                    state_next = SWC_RUN;
                end else begin
                    drt_next = drt_reg + 10'h001;
                end
            end
            default: begin
                state_next = SWC_RESET;
                drt_next   = 10'h000;
            end
        endcase
        // Watchdog reset only drives the core reset; no pin driver exists for it
        core_rst_next = (state_next == SWC_RESET);
        // Oscillator off only while asleep; reset sequence brings it back
        osc_next      = (state_next != SWC_SLEEP);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg    <= SWC_RESET;
            drt_reg      <= 10'h000;
            core_rst_reg <= 1'b1;
            osc_reg      <= 1'b1;
        end else begin
            state_reg    <= state_next;
            drt_reg      <= drt_next;
            core_rst_reg <= core_rst_next;
            osc_reg      <= osc_next;
        end
    end

    // ------------------------------------------------------------
    // Port hold and snapshots
    // ------------------------------------------------------------
    // Pins follow the core only while running, frozen otherwise
    always_comb begin
        pout_next  = pout_reg;
        poe_next   = poe_reg;
        snap_next  = snap_reg;
        csnap_next = csnap_reg;
        if (state_reg == SWC_RUN) begin
            pout_next  = i_core_port_out;
            poe_next   = i_core_port_oe_n;
            csnap_next = i_cmp_out;
            if (i_port_access) begin
                snap_next = i_port_pin;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pout_reg  <= 4'h0;
            poe_reg   <= 4'hf;
            snap_reg  <= 4'h0;
            csnap_reg <= 1'b0;
        end else begin
            pout_reg  <= pout_next;
            poe_reg   <= poe_next;
            snap_reg  <= snap_next;
            csnap_reg <= csnap_next;
        end
    end

    // ------------------------------------------------------------
    // Reset-cause flags
    // ------------------------------------------------------------
    // Priority: reset pin, watchdog, pin change, comparator; pin reset keeps timeout and wake flags, not a same-cycle powerdown change
    always_comb begin
        to_next   = to_reg;
        pd_next   = pd_reg;
        pinw_next = pinw_reg;
        cmpw_next = cmpw_reg;
        if (sleep_go) begin
            to_next = 1'b1;
            pd_next = 1'b0;
        end else if (state_reg == SWC_RUN && i_clrwdt_exec) begin
            to_next = 1'b1;
            pd_next = 1'b1;
        end
        if (ext_rst) begin
            to_next = to_reg;
        end else if (wdt_to) begin
            to_next   = 1'b0;
            pinw_next = 1'b0;
            cmpw_next = 1'b0;
        end else if (pin_wake) begin
            pinw_next = 1'b1;
            cmpw_next = 1'b0;
        end else if (cmp_wake) begin
            cmpw_next = 1'b1;
            pinw_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            to_reg   <= 1'b1;
            pd_reg   <= 1'b1;
            pinw_reg <= 1'b0;
            cmpw_reg <= 1'b0;
        end else begin
            to_reg   <= to_next;
            pd_reg   <= pd_next;
            pinw_reg <= pinw_next;
            cmpw_reg <= cmpw_next;
        end
    end

    // ------------------------------------------------------------
    // Register slave and interrupt
    // ------------------------------------------------------------
    // Every access waits one cycle so read data always comes from a flop
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
    assign wr_ok  = i_avs_write && ack_reg && i_avs_byteenable[0];
    assign rd_ist = i_avs_read && ack_reg && (i_avs_address == `SWC_OFS_IRQ_STAT);

    always_comb begin
        ack_next  = (i_avs_read || i_avs_write) && !ack_reg;
        ctrl_next = ctrl_reg;
        imsk_next = imsk_reg;
        rd_next   = rd_reg;
        if (wr_ok && i_avs_address == `SWC_OFS_CTRL) begin
            ctrl_next = i_avs_writedata[3:0];
        end else if (wr_ok && i_avs_address == `SWC_OFS_IRQ_MASK) begin
            imsk_next = i_avs_writedata[2:0];
        end
        if (i_avs_read && !ack_reg) begin
            rd_next = 32'h00000000;
            if (i_avs_address == `SWC_OFS_FLAGS) begin
                rd_next[`SWC_FLG_TIMEOUT]   = to_reg;
                rd_next[`SWC_FLG_POWERDOWN] = pd_reg;
                rd_next[`SWC_FLG_CMP_WAKE]  = cmpw_reg;
                rd_next[`SWC_FLG_PIN_WAKE]  = pinw_reg;
            end else if (i_avs_address == `SWC_OFS_CTRL) begin
                rd_next[3:0] = ctrl_reg;
            end else if (i_avs_address == `SWC_OFS_IRQ_STAT) begin
                rd_next[2:0] = ist_reg;
            end else if (i_avs_address == `SWC_OFS_IRQ_MASK) begin
                rd_next[2:0] = imsk_reg;
            end else if (i_avs_address == `SWC_OFS_STATE) begin
                rd_next[1:0]            = state_reg;
                rd_next[`SWC_ST_OSC_BIT] = osc_reg;
            end
        end
        // Read clears, but an event in the same cycle still lands
        ist_next = rd_ist ? 3'h0 : ist_reg;
        ist_next[`SWC_IRQ_WAKE]  = ist_next[`SWC_IRQ_WAKE] | any_wake;
        ist_next[`SWC_IRQ_WDT]   = ist_next[`SWC_IRQ_WDT] | wdt_to;
        ist_next[`SWC_IRQ_SLEEP] = ist_next[`SWC_IRQ_SLEEP] | sleep_go;
        irq_next = |(ist_next & imsk_next);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_reg  <= 1'b0;
            ctrl_reg <= `SWC_CTRL_RST;
            imsk_reg <= `SWC_IRQ_MASK_RST;
            ist_reg  <= 3'h0;
            irq_reg  <= 1'b0;
            rd_reg   <= 32'h00000000;
        end else begin
            ack_reg  <= ack_next;
            ctrl_reg <= ctrl_next;
            imsk_reg <= imsk_next;
            ist_reg  <= ist_next;
            irq_reg  <= irq_next;
            rd_reg   <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_avs_readdata         = rd_reg;
    assign o_irq                  = irq_reg;
    assign o_core_rst             = core_rst_reg;
    assign o_osc_en               = osc_reg;
    assign o_timeout_flag         = to_reg;
    assign o_powerdown_flag       = pd_reg;
    assign o_pin_change_wake_flag = pinw_reg;
    assign o_comparator_wake_flag = cmpw_reg;
    assign o_port_pin             = pout_reg;
    assign o_port_pin_oe_n        = poe_reg;
endmodule

// [tb/swc_sleep_wakeup_control_assertions.sv]
// Concurrent checks on sleep entry, wake-up and cause flags
`timescale 1ns/1ps
module swc_sleep_wakeup_control_assertions #(
    parameter int WDT_PERIOD_US = 3
) (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_sleep_exec,
    input wire logic       i_clrwdt_exec,
    input wire logic       o_core_rst,
    input wire logic       o_osc_en,
    input wire logic       o_timeout_flag,
    input wire logic       o_powerdown_flag,
    input wire logic       o_pin_change_wake_flag,
    input wire logic       o_comparator_wake_flag,
    input wire logic [3:0] o_port_pin,
    input wire logic [3:0] o_port_pin_oe_n
);
    // ------------------------------------------------------------
    // Properties, all on the one main clock
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    wire run_w = !o_core_rst && o_osc_en;
    wire [3:0] flg_w = {o_comparator_wake_flag, o_pin_change_wake_flag, o_timeout_flag, o_powerdown_flag};

    sleep_entry_a: assert property (run_w && i_sleep_exec |=> !o_osc_en && o_timeout_flag && !o_powerdown_flag)
        else $error("sleep entry outputs wrong");
    sleep_only_a: assert property ($fell(o_osc_en) |-> $past(i_sleep_exec))
        else $error("oscillator stopped without sleep");
    port_hold_a: assert property (!o_osc_en && $past(!o_osc_en) |-> $stable({o_port_pin, o_port_pin_oe_n}))
        else $error("port drive changed while asleep");
    wake_reset_a: assert property (!o_osc_en ##1 o_osc_en |-> o_core_rst)
        else $error("left sleep without device reset");
    pin_flags_a: assert property ($rose(o_pin_change_wake_flag) |-> flg_w == 4'h6 && o_core_rst)
        else $error("pin wake flags wrong");
    cmp_flags_a: assert property ($rose(o_comparator_wake_flag) |-> flg_w == 4'ha && o_core_rst)
        else $error("comparator wake flags wrong");
    flag_hold_a: assert property ((run_w && !i_sleep_exec && !i_clrwdt_exec) ##1 !o_core_rst |-> $stable(flg_w))
        else $error("cause flags changed without reset");
    wdt_clear_a: assert property ($fell(o_timeout_flag) |-> o_core_rst && !o_pin_change_wake_flag)
        else $error("timeout flag cleared without watchdog reset");
    pd_clear_a: assert property ($fell(o_powerdown_flag) |-> $past(i_sleep_exec))
        else $error("powerdown flag cleared without sleep");

    // Main scenarios seen at least once
    cov_sleep_c: cover property ($fell(o_osc_en));
    cov_pin_c: cover property ($rose(o_pin_change_wake_flag));
    cov_cmp_c: cover property ($rose(o_comparator_wake_flag));
    cov_wdt_c: cover property ($fell(o_timeout_flag));
endmodule

bind swc_sleep_wakeup_control swc_sleep_wakeup_control_assertions #(.WDT_PERIOD_US(WDT_PERIOD_US)) u_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sleep_exec(i_sleep_exec), .i_clrwdt_exec(i_clrwdt_exec),
    .o_core_rst(o_core_rst), .o_osc_en(o_osc_en), .o_timeout_flag(o_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag), .o_pin_change_wake_flag(o_pin_change_wake_flag),
    .o_comparator_wake_flag(o_comparator_wake_flag), .o_port_pin(o_port_pin),
    .o_port_pin_oe_n(o_port_pin_oe_n)
);

// [tb/swc_core_model.sv]
// Processor core model: port drive, port reads and sleep instruction
`timescale 1ns/1ps
module swc_core_model (
    // Clock and device reset
    input  wire logic i_clk,
    input  wire logic i_core_rst,
    // Instruction events and port drive
    output logic       o_sleep_exec,
    output logic       o_port_access,
    output logic [3:0] o_port_out,
    output logic [3:0] o_port_oe_n
);
    // ------------------------------------------------------------
    // Core actions
    // ------------------------------------------------------------
    initial begin
        o_sleep_exec = 1'b0;
        o_port_access = 1'b0;
        o_port_out = 4'h0;
        o_port_oe_n = 4'hf;
    end

    // A core held in reset executes nothing, so wait for it to run
    task automatic wait_run();
        @(posedge i_clk);
        while (i_core_rst !== 1'b0) @(posedge i_clk);
    endtask

    task automatic drive(input logic [3:0] v, input logic [3:0] oe_n);
        @(posedge i_clk);
        o_port_out <= v;
        o_port_oe_n <= oe_n;
    endtask

    // Read the port just before sleep unless told to skip it
    task automatic read_sleep(input logic rd);
        wait_run();
        o_port_access <= rd;
        @(posedge i_clk);
        o_port_access <= 1'b0;
        o_sleep_exec <= 1'b1;
        @(posedge i_clk);
        o_sleep_exec <= 1'b0;
    endtask
endmodule

// [tb/test_sleep_wakeup_control.sv]
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`include "swc_consts.svh"
module test_sleep_wakeup_control;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cmp = 1'b0, rpin_n = 1'b1, clrw = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  pin = 4'h0, pout, poe_n, cout, coe_n, be = 4'hf;
    logic        waitreq, irq, sleep_x, acc, core_rst, osc, to_f, pd_f, pin_f, cmp_f;
    logic [15:0] lfsr = 16'h36e5;
    logic [3:0]  hold;
    int          num_errors = 0, samples_checked = 0;
    wire  [3:0]  flg = {cmp_f, pin_f, to_f, pd_f};

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Design, core model and helpers
    // ------------------------------------------------------------
    swc_sleep_wakeup_control #(.WDT_PERIOD_US(3)) dut (
        .i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .o_irq(irq), .i_sleep_exec(sleep_x), .i_clrwdt_exec(clrw),
        .i_port_access(acc), .i_core_port_out(cout), .i_core_port_oe_n(coe_n), .o_core_rst(core_rst),
        .o_osc_en(osc), .o_timeout_flag(to_f), .o_powerdown_flag(pd_f), .o_pin_change_wake_flag(pin_f),
        .o_comparator_wake_flag(cmp_f), .i_external_reset_pin_n(rpin_n), .i_port_pin(pin),
        .i_cmp_out(cmp), .o_port_pin(pout), .o_port_pin_oe_n(poe_n));

    swc_core_model core (.i_clk(clk), .i_core_rst(core_rst), .o_sleep_exec(sleep_x),
        .o_port_access(acc), .o_port_out(cout), .o_port_oe_n(coe_n));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected {cmp, pin, timeout, powerdown} after a wake: 0 pin, 1 comparator, 2 watchdog
    function automatic logic [3:0] wake_flags(input int src);
        return (src == 0) ? 4'h6 : (src == 1) ? 4'ha : 4'h0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        if (n >= 20) num_errors++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Wait for the device reset that a wake produces, within a bound
    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (core_rst !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(core_rst, 1'b1);
        chk(osc, 1'b1);
    endtask

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        pin <= lfsr[3:0];
        #1;
        chk(flg, 4'h3);
        bus(1'b0, `SWC_OFS_CTRL, 32'h0);
        chk(q, 32'h9);
        bus(1'b0, 5'h14, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `SWC_OFS_CTRL, 32'h6);
        // A write without its low byte lane must leave the enables alone
        be <= 4'he;
        bus(1'b1, `SWC_OFS_CTRL, 32'h1);
        be <= 4'hf;
        bus(1'b0, `SWC_OFS_CTRL, 32'h0);
        chk(q, 32'h6);
        bus(1'b1, `SWC_OFS_IRQ_MASK, 32'h1);
        // Pin-change wake on each watched pin, random port drive
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            core.drive(lfsr[3:0], lfsr[7:4]);
            core.read_sleep(1'b1);
            #1;
            chk({osc, to_f, pd_f}, 3'b010);
            hold = pout;
            core.drive(~lfsr[3:0], ~lfsr[7:4]);
            bus(1'b0, `SWC_OFS_STATE, 32'h0);
            chk(q, 32'h1);
            #1;
            chk(pout, hold);
            @(posedge clk) pin[(k == 2) ? 3 : k] <= ~pin[(k == 2) ? 3 : k];
            wait_rst(20);
            chk(flg, wake_flags(0));
            chk(irq, 1'b1);
            bus(1'b0, `SWC_OFS_IRQ_STAT, 32'h0);
            chk(q[0], 1'b1);
            repeat (2) @(posedge clk);
            chk(irq, 1'b0);
        end
        // Pin source disabled: no wake; comparator then wakes
        bus(1'b1, `SWC_OFS_CTRL, 32'h4);
        core.read_sleep(1'b1);
        @(posedge clk) pin[0] <= ~pin[0];
        repeat (20) @(posedge clk);
        #1;
        chk({core_rst, osc}, 2'b00);
        @(posedge clk) cmp <= ~cmp;
        wait_rst(20);
        chk(flg, wake_flags(1));
        // Pin 0 still differs from the last read, so sleep without a read wakes at once
        bus(1'b1, `SWC_OFS_CTRL, 32'h6);
        core.read_sleep(1'b0);
        wait_rst(5);
        chk(flg, wake_flags(0));
        // Enable only once running, so the short sim period cannot expire inside the reset timer;
        // clear pulses keep it quiet in run, then it counts through sleep and wakes the device
        core.wait_run();
        bus(1'b1, `SWC_OFS_CTRL, 32'h1);
        repeat (4) begin
            repeat (150) @(posedge clk);
            clrw <= 1'b1;
            @(posedge clk) clrw <= 1'b0;
        end
        #1;
        chk({core_rst, flg}, 5'h07);
        core.read_sleep(1'b1);
        wait_rst(1000);
        chk(flg, wake_flags(2));
        // Reset pin wake leaves the cause flags as sleep left them
        bus(1'b1, `SWC_OFS_CTRL, 32'h8);
        core.read_sleep(1'b1);
        @(posedge clk) rpin_n <= 1'b0;
        wait_rst(20);
        chk(flg, 4'h2);
        @(posedge clk) rpin_n <= 1'b1;
        core.wait_run();
        conclude();
    end
endmodule
